//--- hw/tss_top.sv
// Purpose: Transmit status flags, collision retry, station and filter bytes.
// Assumes: Host strobes and transmitter events are one-cycle pulses on REF_CLK.
// Notes:   Host reads return data two cycles after the read strobe.
`timescale 1ns/10ps
module tss_top #(
	parameter int SELF_RX_WIN = tss_pkg::SELF_RX_WIN_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic [3:0]  HOST_ADDR,
	input  wire logic [1:0]  HOST_BANK,
	input  wire logic        HOST_WR,
	input  wire logic        HOST_RD,
	input  wire logic [7:0]  HOST_WDATA,
	output logic      [7:0]  HOST_RDATA,
	output logic             HOST_RVALID,
	output logic             HOST_IRQ,
	input  wire logic        CARRIER_SENSE,
	input  wire logic        TX_FRAME_BEGIN,
	input  wire logic        TX_FRAME_END,
	input  wire logic        TX_COLLISION,
	input  wire logic        JABBER_EVENT,
	input  wire logic        RX_GOOD_FRAME,
	output logic             TX_ENABLE,
	output logic             TX_RETRY,
	output logic             TX_SKIP,
	input  wire logic [13:0] CABLE_TEST_COUNT,
	output logic      [47:0] STATION_ADDRESS,
	output logic      [63:0] MULTICAST_FILTER,
	input  wire logic [7:0]  TX_HDR_LOW,
	input  wire logic [7:0]  TX_HDR_HIGH,
	output logic      [10:0] TX_FRAME_LENGTH,
	input  wire logic        RX_HDR_LOAD,
	input  wire logic [4:0]  RX_HDR_FLAGS,
	input  wire logic [10:0] RX_HDR_LENGTH,
	output logic      [31:0] RX_HEADER
);
	// ========================================================================
	// Decoding shared by read and write paths.
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic store_hit(input logic [3:0] a, input logic [1:0] b);
		store_hit = ((b == tss_pkg::BANK_STATION) && (a >= tss_pkg::OFS_STATION0)
			&& (a < tss_pkg::OFS_CABLE_LOW))
			|| ((b == tss_pkg::BANK_FILTER) && (a >= tss_pkg::OFS_STATION0));
	endfunction

	function automatic logic [3:0] store_index(input logic [3:0] a, input logic [1:0] b);
		logic [3:0] base;
		base = a - tss_pkg::OFS_STATION0;
		store_index = (b == tss_pkg::BANK_FILTER) ? (base + 4'(tss_pkg::STATION_BYTES)) : base;
	endfunction

	// ========================================================================
	// Declarations.
	tss_pkg::tss_state_t state;
	tss_pkg::tss_state_t next_state;
	logic [7:0]  irq_en;
	logic [2:0]  mode_low;
	logic [3:0]  col_count;
	logic [6:0]  pkt_left;
	logic        in_frame;
	logic        carrier_prev;
	logic        done_flag;
	logic        self_rx_flag;
	logic        drop_flag;
	logic        jabber_flag;
	logic        col_flag;
	logic        xs_col_flag;
	logic [15:0] win_count;
	logic [7:0]  status_image;
	logic        status_wr;
	logic        launch_wr;
	logic        col_event;
	logic        col_final;
	logic        frame_ok;
	logic        pkt_finish;
	logic        bank_finish;
	logic        rd_pend;
	logic        rd_from_store;
	logic [7:0]  rd_hold;
	logic [7:0]  rd_direct;
	logic [7:0]  store_q;
	logic [tss_pkg::STORE_BYTES*8-1:0] store_flat;

	assign status_wr   = HOST_WR && hit(HOST_ADDR, tss_pkg::OFS_TX_STATUS);
	assign launch_wr   = HOST_WR && (HOST_BANK == tss_pkg::BANK_BUFFER)
		&& hit(HOST_ADDR, tss_pkg::OFS_TX_LAUNCH);
	assign col_event   = TX_COLLISION && (state == tss_pkg::TSS_SEND);
	assign col_final   = col_event && (col_count == tss_pkg::LAST_COLLISION);
	assign frame_ok    = TX_FRAME_END && !TX_COLLISION && (state == tss_pkg::TSS_SEND);
	assign pkt_finish  = frame_ok || col_final;
	assign bank_finish = pkt_finish && (pkt_left == 7'h01);

	// ========================================================================
	// Transmit sequencer.
	always_comb begin
		next_state = state;
		case (state)
			tss_pkg::TSS_IDLE: begin
				if (launch_wr && HOST_WDATA[tss_pkg::BIT_LAUNCH_START]
					&& (HOST_WDATA[6:0] != 7'h00)) begin
					next_state = tss_pkg::TSS_SEND;
				end
			end
			tss_pkg::TSS_SEND: begin
				if (bank_finish) begin
					next_state = tss_pkg::TSS_IDLE;
				end
			end
			default: begin
				next_state = tss_pkg::TSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state <= tss_pkg::TSS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pkt_left <= 7'h00;
		end else if ((state == tss_pkg::TSS_IDLE) && (next_state == tss_pkg::TSS_SEND)) begin
			pkt_left <= HOST_WDATA[6:0];
		end else if (pkt_finish) begin
			pkt_left <= pkt_left - 7'h01;
		end
	end

	assign TX_ENABLE = (state == tss_pkg::TSS_SEND);

	// ========================================================================
	// Collision counting and retry.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			col_count <= tss_pkg::RST_COUNT;
			TX_RETRY  <= 1'b0;
			TX_SKIP   <= 1'b0;
		end else begin
			TX_RETRY <= col_event && !col_final;
			TX_SKIP  <= col_final;
			if (col_final || frame_ok) begin
				col_count <= tss_pkg::RST_COUNT;
			end else if (col_event) begin
				col_count <= col_count + 4'h1;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			in_frame     <= 1'b0;
			carrier_prev <= 1'b0;
		end else begin
			carrier_prev <= CARRIER_SENSE;
			if (TX_FRAME_BEGIN) begin
				in_frame <= 1'b1;
			end else if (TX_FRAME_END || TX_COLLISION) begin
				in_frame <= 1'b0;
			end
		end
	end

	// ========================================================================
	// Latched status flags; a set event wins over a same-cycle clear by the host or, for drop_flag, by TX_FRAME_BEGIN.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			done_flag <= 1'b0;
		end else if (bank_finish) begin
			done_flag <= 1'b1;
		end else if (status_wr && HOST_WDATA[tss_pkg::BIT_TX_DONE]) begin
			done_flag <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			jabber_flag <= 1'b0;
		end else if (JABBER_EVENT) begin
			jabber_flag <= 1'b1;
		end else if (status_wr && HOST_WDATA[tss_pkg::BIT_JABBER]) begin
			jabber_flag <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			col_flag <= 1'b0;
		end else if (col_event) begin
			col_flag <= 1'b1;
		end else if (status_wr && HOST_WDATA[tss_pkg::BIT_COLLISION]) begin
			col_flag <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			xs_col_flag <= 1'b0;
		end else if (col_final) begin
			xs_col_flag <= 1'b1;
		end else if (status_wr && HOST_WDATA[tss_pkg::BIT_XS_COL]) begin
			xs_col_flag <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			drop_flag <= 1'b0;
		end else if (in_frame && carrier_prev && !CARRIER_SENSE) begin
			drop_flag <= 1'b1;
		end else if (TX_FRAME_BEGIN) begin
			drop_flag <= 1'b0;
		end
	end

	// ========================================================================
	// Self-reception window and flag.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			win_count <= 16'h0000;
		end else if (frame_ok) begin
			win_count <= 16'(SELF_RX_WIN);
		end else if (win_count != 16'h0000) begin
			win_count <= win_count - 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			self_rx_flag <= 1'b0;
		end else if (RX_GOOD_FRAME && (win_count != 16'h0000)) begin
			self_rx_flag <= 1'b1;
		end else if (TX_FRAME_BEGIN
			|| (status_wr && HOST_WDATA[tss_pkg::BIT_SELF_RX])) begin
			self_rx_flag <= 1'b0;
		end
	end

	always_comb begin
		status_image = tss_pkg::RST_BYTE;
		status_image[tss_pkg::BIT_TX_DONE]   = done_flag;
		status_image[tss_pkg::BIT_CARRIER]   = CARRIER_SENSE;
		status_image[tss_pkg::BIT_SELF_RX]   = self_rx_flag;
		status_image[tss_pkg::BIT_CR_DROP]   = drop_flag;
		status_image[tss_pkg::BIT_JABBER]    = jabber_flag;
		status_image[tss_pkg::BIT_COLLISION] = col_flag;
		status_image[tss_pkg::BIT_XS_COL]    = xs_col_flag;
	end

	// ========================================================================
	// Interrupt enable, mode register and interrupt output.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			irq_en   <= tss_pkg::RST_BYTE;
			mode_low <= 3'h0;
		end else if (HOST_WR) begin
			if (hit(HOST_ADDR, tss_pkg::OFS_TX_IRQ_EN)) begin
				irq_en <= HOST_WDATA & tss_pkg::IRQ_EN_MASK;
			end
			if (hit(HOST_ADDR, tss_pkg::OFS_TX_MODE)) begin
				mode_low <= HOST_WDATA[2:0];
			end
		end
	end

	assign HOST_IRQ = |(status_image & irq_en & tss_pkg::IRQ_EN_MASK);

	// ========================================================================
	// Station address and multicast filter store.
	tss_byte_store #(
		.DEPTH (tss_pkg::STORE_BYTES),
		.AW    (4)
	) u_store (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.wr_en   (HOST_WR && store_hit(HOST_ADDR, HOST_BANK)),
		.wr_addr (store_index(HOST_ADDR, HOST_BANK)),
		.wr_data (HOST_WDATA),
		.rd_en   (HOST_RD),
		.rd_addr (store_index(HOST_ADDR, HOST_BANK)),
		.rd_data (store_q),
		.flat    (store_flat)
	);

	assign STATION_ADDRESS  = store_flat[47:0];
	assign MULTICAST_FILTER = store_flat[111:48];

	// ========================================================================
	// Host read path: two-cycle latency from strobe to data.
	always_comb begin
		rd_direct = tss_pkg::RST_BYTE;
		if (hit(HOST_ADDR, tss_pkg::OFS_TX_STATUS)) begin
			rd_direct = status_image;
		end else if (hit(HOST_ADDR, tss_pkg::OFS_TX_IRQ_EN)) begin
			rd_direct = irq_en;
		end else if (hit(HOST_ADDR, tss_pkg::OFS_TX_MODE)) begin
			rd_direct = {col_count, 1'b0, mode_low};
		end else if (HOST_BANK == tss_pkg::BANK_STATION) begin
			if (hit(HOST_ADDR, tss_pkg::OFS_CABLE_LOW)) begin
				rd_direct = CABLE_TEST_COUNT[7:0];
			end else if (hit(HOST_ADDR, tss_pkg::OFS_CABLE_HIGH)) begin
				rd_direct = {2'b00, CABLE_TEST_COUNT[13:8]};
			end
		end else if ((HOST_BANK == tss_pkg::BANK_BUFFER)
			&& hit(HOST_ADDR, tss_pkg::OFS_TX_LAUNCH)) begin
			rd_direct = {TX_ENABLE, pkt_left};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rd_pend       <= 1'b0;
			rd_from_store <= 1'b0;
			rd_hold       <= tss_pkg::RST_BYTE;
		end else begin
			rd_pend <= HOST_RD;
			if (HOST_RD) begin
				rd_from_store <= store_hit(HOST_ADDR, HOST_BANK);
				rd_hold       <= rd_direct;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			HOST_RDATA  <= tss_pkg::RST_BYTE;
			HOST_RVALID <= 1'b0;
		end else begin
			HOST_RVALID <= rd_pend;
			if (rd_pend) begin
				HOST_RDATA <= rd_from_store ? store_q : rd_hold;
			end
		end
	end

	// ========================================================================
	// Packet headers in buffer memory.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_FRAME_LENGTH <= 11'h000;
			RX_HEADER       <= 32'h00000000;
		end else begin
			TX_FRAME_LENGTH <= {TX_HDR_HIGH[2:0], TX_HDR_LOW};
			if (RX_HDR_LOAD) begin
				RX_HEADER <= {5'h00, RX_HDR_LENGTH[10:8], RX_HDR_LENGTH[7:0],
					8'h00, 2'b00, RX_HDR_FLAGS, 1'b0};
			end
		end
	end
endmodule

//--- hw/tss_pkg.sv
// Purpose: Shared constants for the transmit status and station register block.
// Assumes: Byte-wide host register port, one 100 MHz clock.
// Notes:   Register offsets, status and launch bit positions, byte reset values and the self-reception window timing live here.
package tss_pkg;
	// ========================================================================
	// Register offsets within the 16-byte window.
	localparam logic [3:0] OFS_TX_STATUS   = 4'h0;
	localparam logic [3:0] OFS_TX_IRQ_EN   = 4'h2;
	localparam logic [3:0] OFS_TX_MODE     = 4'h4;
	localparam logic [3:0] OFS_STATION0    = 4'h8;
	localparam logic [3:0] OFS_CABLE_LOW   = 4'hE;
	localparam logic [3:0] OFS_CABLE_HIGH  = 4'hF;
	localparam logic [3:0] OFS_TX_LAUNCH   = 4'hA;
	// Register bank select values for offsets 8 to 15.
	localparam logic [1:0] BANK_STATION    = 2'h0;
	localparam logic [1:0] BANK_FILTER     = 2'h1;
	localparam logic [1:0] BANK_BUFFER     = 2'h2;
	// ========================================================================
	// Transmit status bit positions.
	localparam int BIT_TX_DONE   = 7;
	localparam int BIT_CARRIER   = 6;
	localparam int BIT_SELF_RX   = 5;
	localparam int BIT_CR_DROP   = 4;
	localparam int BIT_JABBER    = 3;
	localparam int BIT_COLLISION = 2;
	localparam int BIT_XS_COL    = 1;
	localparam logic [7:0] IRQ_EN_MASK  = 8'h8E;
	localparam logic [7:0] TX_MODE_MASK = 8'h07;
	localparam int BIT_LAUNCH_START = 7;
	// ========================================================================
	// Reset values.
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [3:0] RST_COUNT = 4'h0;
	// ========================================================================
	// Collision retry limit and byte stores.
	localparam logic [3:0] LAST_COLLISION = 4'hF;
	localparam int STATION_BYTES = 6;
	localparam int FILTER_BYTES  = 8;
	localparam int STORE_BYTES   = STATION_BYTES + FILTER_BYTES;
	localparam int CABLE_BITS    = 14;
	localparam int LENGTH_BITS   = 11;
	// ========================================================================
	// Receive header status byte field positions.
	localparam int HDR_GOOD   = 5;
	localparam int HDR_REMOTE = 4;
	localparam int HDR_SHORT  = 3;
	localparam int HDR_ALIGN  = 2;
	localparam int HDR_CRC    = 1;
	// ========================================================================
	// Self-reception window after a frame ends.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SELF_RX_WIN_NS = 25600;
	localparam int SELF_RX_WIN_CYC = SELF_RX_WIN_NS / CLK_PERIOD_NS;
	// ========================================================================
	// Transmit sequencer states.
	typedef enum logic [1:0] {
		TSS_IDLE = 2'b01,
		TSS_SEND = 2'b10
	} tss_state_t;
endpackage

//--- hw/tss_byte_store.sv
// Purpose: Byte store for the station address and multicast filter.
// Assumes: One write and one read port, synchronous to the clock.
// Notes:   Read data come out of a register one cycle after the request.
`timescale 1ns/10ps
module tss_byte_store #(
	parameter int DEPTH = tss_pkg::STORE_BYTES,
	parameter int AW    = 4
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              wr_en,
	input  wire logic [AW-1:0]     wr_addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              rd_en,
	input  wire logic [AW-1:0]     rd_addr,
	output logic      [7:0]        rd_data,
	output logic      [DEPTH*8-1:0] flat
);
	// ========================================================================
	// Storage.
	logic [7:0] mem [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_byte
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					mem[g] <= tss_pkg::RST_BYTE;
				end else if (wr_en && (wr_addr == AW'(g))) begin
					mem[g] <= wr_data;
				end
			end
			assign flat[g*8 +: 8] = mem[g];
		end
	endgenerate

	// ========================================================================
	// Registered read.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= tss_pkg::RST_BYTE;
		end else if (rd_en) begin
			rd_data <= (32'(rd_addr) < DEPTH) ? mem[rd_addr] : tss_pkg::RST_BYTE;
		end
	end
endmodule

//--- tb/tss_checker.sv
// Purpose: Port checker for the transmit status block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to tss_top below the module.
`timescale 1ns/10ps
module tss_checker (
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic [3:0]  HOST_ADDR,
	input wire logic [1:0]  HOST_BANK,
	input wire logic        HOST_WR,
	input wire logic        HOST_RD,
	input wire logic [7:0]  HOST_WDATA,
	input wire logic        HOST_RVALID,
	input wire logic        HOST_IRQ,
	input wire logic        TX_FRAME_END,
	input wire logic        TX_COLLISION,
	input wire logic        TX_ENABLE,
	input wire logic        TX_RETRY,
	input wire logic        TX_SKIP,
	input wire logic [7:0]  TX_HDR_LOW,
	input wire logic [7:0]  TX_HDR_HIGH,
	input wire logic [10:0] TX_FRAME_LENGTH,
	input wire logic        RX_HDR_LOAD,
	input wire logic [4:0]  RX_HDR_FLAGS,
	input wire logic [10:0] RX_HDR_LENGTH,
	input wire logic [31:0] RX_HEADER
);
	// ====
	// Expected header images and read sequences.
	logic [10:0] hdr_len;
	logic [31:0] rx_exp;
	assign hdr_len = {TX_HDR_HIGH[2:0], TX_HDR_LOW};
	assign rx_exp  = {5'h00, RX_HDR_LENGTH, 8'h00, 2'b00, RX_HDR_FLAGS, 1'b0};
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_read_req;
		HOST_RD;
	endsequence
	sequence s_read_ans;
		##2 HOST_RVALID;
	endsequence
	// ====
	// Assertions.
	chk_read_answer: assert property (s_read_req |-> s_read_ans)
		else $error("read answer missing");
	chk_answer_cause: assert property (HOST_RVALID |-> $past(HOST_RD, 2))
		else $error("read answer without request");
	chk_retry_follow: assert property (TX_ENABLE && TX_COLLISION |=> TX_RETRY ^ TX_SKIP)
		else $error("collision without one retry outcome");
	chk_skip_cause: assert property (TX_SKIP |-> $past(TX_ENABLE && TX_COLLISION))
		else $error("skip without collision");
	chk_done_cause: assert property ($past(RST_N) && $fell(TX_ENABLE) |->
		$past(TX_FRAME_END || TX_COLLISION)) else $error("send ended without cause");
	chk_launch_cause: assert property ($past(RST_N) && $rose(TX_ENABLE) |->
		$past(HOST_WR && HOST_BANK == tss_pkg::BANK_BUFFER
		&& HOST_ADDR == tss_pkg::OFS_TX_LAUNCH && HOST_WDATA[7]))
		else $error("send started without launch");
	chk_irq_clear: assert property ($past(RST_N) && $fell(HOST_IRQ) |-> $past(HOST_WR))
		else $error("interrupt fell without host write");
	chk_tx_length: assert property ($past(RST_N) |-> TX_FRAME_LENGTH == $past(hdr_len))
		else $error("frame length wrong");
	chk_rx_header: assert property ($past(RST_N) && $past(RX_HDR_LOAD) |->
		RX_HEADER == $past(rx_exp)) else $error("receive header wrong");
endmodule
bind tss_top tss_checker i_tss_checker (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.HOST_ADDR(HOST_ADDR), .HOST_BANK(HOST_BANK), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
	.HOST_WDATA(HOST_WDATA), .HOST_RVALID(HOST_RVALID), .HOST_IRQ(HOST_IRQ),
	.TX_FRAME_END(TX_FRAME_END), .TX_COLLISION(TX_COLLISION), .TX_ENABLE(TX_ENABLE),
	.TX_RETRY(TX_RETRY), .TX_SKIP(TX_SKIP), .TX_HDR_LOW(TX_HDR_LOW),
	.TX_HDR_HIGH(TX_HDR_HIGH), .TX_FRAME_LENGTH(TX_FRAME_LENGTH),
	.RX_HDR_LOAD(RX_HDR_LOAD), .RX_HDR_FLAGS(RX_HDR_FLAGS),
	.RX_HDR_LENGTH(RX_HDR_LENGTH), .RX_HEADER(RX_HEADER));

//--- tb/tss_host.sv
// Purpose: Host processor model on the byte register port.
// Assumes: Strobes are one-cycle pulses launched after a clock edge.
// Notes:   Released address and data show the inverse of the last value.
`timescale 1ns/10ps
module tss_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid,
	output logic      [3:0] addr,
	output logic      [1:0] bank,
	output logic            wr,
	output logic            rd,
	output logic      [7:0] wdata
);
	initial begin
		addr = 4'h0;
		bank = 2'h0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
	end
	task automatic wr_reg(input logic [1:0] b, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		bank = b;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	task automatic rd_reg(input logic [1:0] b, input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		bank = b;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		addr = ~a;
		for (int i = 0; i < 4 && rvalid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		d = (rvalid === 1'b1) ? rdata : 8'hXX;
	endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench for the transmit status block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Self-reception window shortened to 20 cycles.
`timescale 1ns/10ps
module testbench;
	localparam logic [4:0] BEG = 5'h01, FEND = 5'h02, COL = 5'h04, JAB = 5'h08, RXG = 5'h10;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         cs = 1'b0;
	logic [4:0]   ev = 5'h00;
	logic         hdr_load = 1'b0;
	logic [4:0]   hdr_flags = 5'h00;
	logic [10:0]  hdr_len = 11'h000;
	logic [15:0]  tx_hdr = 16'h0000;
	logic [13:0]  cable = 14'h0000;
	logic [111:0] exp_st;
	logic [7:0]   d;
	logic [3:0]   h_addr;
	logic [1:0]   h_bank;
	logic         h_wr, h_rd, h_rvalid, irq, tx_en;
	logic [7:0]   h_wdata, h_rdata;
	logic [47:0]  station;
	logic [63:0]  filter;
	logic [10:0]  tx_len;
	logic [31:0]  rx_hdr;
	int           n_fail = 0, n_tests = 0, seed = 23961, n_retry = 0, n_skip = 0;
	logic         retry, skip;
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (retry === 1'b1) n_retry++;
		if (skip === 1'b1) n_skip++;
	end
	tss_top #(.SELF_RX_WIN(20)) i_tss_top (.REF_CLK(ref_clk), .RST_N(rst_n),
		.HOST_ADDR(h_addr), .HOST_BANK(h_bank), .HOST_WR(h_wr), .HOST_RD(h_rd),
		.HOST_WDATA(h_wdata), .HOST_RDATA(h_rdata), .HOST_RVALID(h_rvalid), .HOST_IRQ(irq),
		.CARRIER_SENSE(cs), .TX_FRAME_BEGIN(ev[0]), .TX_FRAME_END(ev[1]),
		.TX_COLLISION(ev[2]), .JABBER_EVENT(ev[3]), .RX_GOOD_FRAME(ev[4]),
		.TX_ENABLE(tx_en), .TX_RETRY(retry), .TX_SKIP(skip), .CABLE_TEST_COUNT(cable),
		.STATION_ADDRESS(station), .MULTICAST_FILTER(filter), .TX_HDR_LOW(tx_hdr[7:0]),
		.TX_HDR_HIGH(tx_hdr[15:8]), .TX_FRAME_LENGTH(tx_len), .RX_HDR_LOAD(hdr_load),
		.RX_HDR_FLAGS(hdr_flags), .RX_HDR_LENGTH(hdr_len), .RX_HEADER(rx_hdr));
	tss_host i_tss_host (.clk(ref_clk), .rdata(h_rdata), .rvalid(h_rvalid), .addr(h_addr),
		.bank(h_bank), .wr(h_wr), .rd(h_rd), .wdata(h_wdata));
	// ====
	// Checking helpers.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [1:0] b, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_tss_host.rd_reg(b, a, v);
		chk(64'(v), 64'(e));
	endtask
	task automatic pulse(input logic [4:0] v);
		@(posedge ref_clk);
		#1;
		ev = v;
		@(posedge ref_clk);
		#1;
		ev = 5'h00;
	endtask
	function automatic logic [7:0] f_status(input logic [7:0] latched);
		return latched | {1'b0, cs, 6'h00};
	endfunction
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		print_verdict;
	end
	// ====
	// Main sequence.
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		rc(0, tss_pkg::OFS_TX_STATUS, f_status(8'h00));
		cs = 1'b1;
		rc(0, tss_pkg::OFS_TX_STATUS, f_status(8'h00));
		rc(0, tss_pkg::OFS_TX_MODE, 8'h00);
		i_tss_host.wr_reg(0, tss_pkg::OFS_TX_MODE, 8'hFF);
		rc(0, tss_pkg::OFS_TX_MODE, tss_pkg::TX_MODE_MASK);
		i_tss_host.wr_reg(0, tss_pkg::OFS_TX_MODE, 8'h00);
		rc(0, 4'h6, 8'h00);
		for (int i = 0; i < 14; i++) begin
			d = 8'($random(seed));
			exp_st[i*8 +: 8] = d;
			i_tss_host.wr_reg((i < 6) ? 2'h0 : 2'h1, 4'(8 + ((i < 6) ? i : i - 6)), d);
		end
		chk(64'(station), 64'(exp_st[47:0]));
		chk(filter, exp_st[111:48]);
		rc(tss_pkg::BANK_STATION, 4'hD, exp_st[47:40]);
		rc(tss_pkg::BANK_FILTER, 4'hF, exp_st[111:104]);
		cable = 14'($random(seed));
		rc(0, tss_pkg::OFS_CABLE_LOW, cable[7:0]);
		rc(0, tss_pkg::OFS_CABLE_HIGH, {2'b00, cable[13:8]});
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			#1;
			{hdr_flags, hdr_len, tx_hdr} = 32'($random(seed));
			tx_hdr[15:11] = 5'h00;
			hdr_load = 1'b1;
			@(posedge ref_clk);
			#1;
			hdr_load = 1'b0;
			chk(64'(rx_hdr), 64'({5'h00, hdr_len, 8'h00, 2'b00, hdr_flags, 1'b0}));
			chk(64'(tx_len), 64'(tx_hdr[10:0]));
		end
		i_tss_host.wr_reg(0, tss_pkg::OFS_TX_IRQ_EN, 8'hFF);
		rc(0, tss_pkg::OFS_TX_IRQ_EN, tss_pkg::IRQ_EN_MASK);
		i_tss_host.wr_reg(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h81);
		chk(64'(tx_en), 64'h1);
		pulse(BEG);
		pulse(FEND);
		pulse(RXG);
		chk(64'(tx_en), 64'h0);
		chk(64'(irq), 64'h1);
		rc(0, 0, f_status(8'hA0));
		i_tss_host.wr_reg(0, 0, 8'h00);
		rc(0, 0, f_status(8'hA0));
		i_tss_host.wr_reg(0, 0, 8'h20);
		rc(0, 0, f_status(8'h80));
		i_tss_host.wr_reg(0, 0, 8'h80);
		chk(64'(irq), 64'h0);
		i_tss_host.wr_reg(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h81);
		pulse(BEG);
		cs = 1'b0;
		pulse(FEND);
		fork
			i_tss_host.wr_reg(0, 0, 8'h08);
			pulse(JAB);
		join
		rc(0, 0, 8'h98);
		i_tss_host.wr_reg(0, 0, 8'h98);
		rc(0, 0, 8'h10);
		i_tss_host.wr_reg(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h82);
		i_tss_host.wr_reg(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h85);
		rc(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h82);
		pulse(BEG);
		pulse(FEND);
		rc(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h81);
		pulse(BEG);
		pulse(FEND);
		chk(64'(tx_en), 64'h0);
		rc(0, 0, 8'h80);
		i_tss_host.wr_reg(0, 0, 8'h80);
		i_tss_host.wr_reg(tss_pkg::BANK_BUFFER, tss_pkg::OFS_TX_LAUNCH, 8'h81);
		for (int i = 1; i <= 16; i++) begin
			pulse(BEG);
			pulse(COL);
			if (i == 15) rc(0, tss_pkg::OFS_TX_MODE, 8'hF0);
		end
		rc(0, 0, 8'h86);
		rc(0, tss_pkg::OFS_TX_MODE, 8'h00);
		chk(64'(n_retry), 64'd15);
		chk(64'(n_skip), 64'd1);
		chk(64'(irq), 64'h1);
		i_tss_host.wr_reg(0, 0, 8'h86);
		chk(64'(irq), 64'h0);
		pulse(JAB);
		chk(64'(irq), 64'h1);
		i_tss_host.wr_reg(0, tss_pkg::OFS_TX_IRQ_EN, 8'h02);
		chk(64'(irq), 64'h0);
		i_tss_host.wr_reg(0, 0, 8'h08);
		rc(0, 0, f_status(8'h00));
		print_verdict;
	end
endmodule
